// *** hw/fmaes_defines.vh ***
`ifndef FMAES_DEFINES_VH
`define FMAES_DEFINES_VH
// ----------------------------------------
// Indirect read sequence indices
// ----------------------------------------
`define FMAES_IDX_SUMMARY   3'h0
`define FMAES_IDX_FAC_ALARM 3'h1
`define FMAES_IDX_REM_ALARM 3'h2
`define FMAES_IDX_EXCH_EVT  3'h3
`define FMAES_IDX_NT_EVT    3'h4
`define FMAES_IDX_ALIGN_EVT 3'h5
`define FMAES_IDX_LAST      3'h5
// ----------------------------------------
// Framing modes (monitor_mode_reg field)
// ----------------------------------------
`define FMAES_MODE_ESF      3'h0
`define FMAES_MODE_D4       3'h1
`define FMAES_MODE_D4_JAPAN 3'h2
`define FMAES_MODE_CHAN96   3'h3
`define FMAES_MODE_E1_BASIC 3'h4
`define FMAES_MODE_E1_CRC4  3'h5
// ----------------------------------------
// Interworking timer selections
// ----------------------------------------
`define FMAES_TMR_NONE      2'h0
`define FMAES_TMR_100MS     2'h1
`define FMAES_TMR_400MS     2'h2
// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define FMAES_FAC_FRAME_LOSS_SAME_AS_PRIOR_READ_BIT 3
`define FMAES_FAC_RSVD_MASK 8'hBF
`define FMAES_ALN_RSVD_MASK 8'hC7
`define FMAES_OPT_NO_FORCE  0
`define FMAES_OPT_ESF_SEC   1
`define FMAES_FLAG_RESET    8'h00
`define FMAES_UNAVAIL_SECS  4'hA
`define FMAES_EBIT_SECS     3'h5
`define FMAES_EBIT_MIN      10'h3DF
`define FMAES_ESF_WIN_CHK   6'h21
`define FMAES_ESF_WIN_ERR   6'h20
`define FMAES_ESF_SEC_ERR   9'h140
`define FMAES_E1_WIN_CHK    10'h3E8
`define FMAES_E1_WIN_ERR    10'h392
`endif

// *** hw/fmaes_status.v ***
// Operation
// - Alarm flags latch on detection and hold after the condition ends.
// - Facility alarm bit 0 flags loss of frame alignment.
// - Facility bit 1 flags superframe loss only in D4 and 96-channel formats.
// - Facility bit 2 flags an all-ones alarm from the remote line end.
// - Facility bit 3 reads one when frame-loss state equals that at last read.
// - Facility bit 4 flags missing CRC-4 multiframe; zero if CRC-4 off or DS1.
// - Facility bit 5 flags severely errored frame; bit 6 reserved.
// - Facility bit 7 set only in frame loss with E1 auxiliary pattern.
// - Remote bit 0 yellow alarm; bit 1 Japanese alarm, zero in E1.
// - Remote bit 2 after five seconds each with at least 991 zero E bits.
// - Remote bits 3-7 flag Sa6 codes 1000,1010,1100,1110,1111; zero in DS1.
// - Exchange bits 0-2 flag local errored, bursty, severe seconds.
// - Exchange bit 3 unavailable after 10 severe seconds; G.826 delays 10 s.
// - Exchange bits 4-7 give far-end second flags; zero in DS1.
// - Netterm register zero in DS1; bits 0-3 local second and outage flags.
// - Netterm bits 4-7 far-end flags; outage delayed 10 s in G.826.
// - Alignment bit 0 flags a new frame alignment differing from before.
// - Alignment bit 1 flags superframe lock in D4/96-channel after frame lock.
// - Alignment bit 2 flags CRC multiframe lock; bits 3-5 reserved.
// - ESF excess CRC: 32 of 33, or over 320 per second by option bit 1.
// - E1 excess CRC: over 914 of 1000; forces frame loss if option bit 0 low.
// - Alignment bit 7 flags interworking timer expiry; zero where no timer.
// - Summary bits mirror nonzero detail registers, clearing once details clear.
// - Each access restarts at summary, auto-increments; host holds select low.
`include "fmaes_defines.vh"
module fmaes_status #(
	parameter [3:0] UNAVAIL_SECS = `FMAES_UNAVAIL_SECS,
	parameter [2:0] EBIT_SECS    = `FMAES_EBIT_SECS
) (
	// Clock, reset, enable
	input  wire       core_clk,
	input  wire       rst,
	input  wire       clk_en,
	// Configuration (monitor_mode_reg, monitor_param_reg, checksum_option_reg)
	input  wire [2:0] frame_mode,
	input  wire [1:0] iw_timer_mode,
	input  wire       g826_mode,
	input  wire [1:0] checksum_option,
	// Framer conditions, same clock domain
	input  wire       one_sec_pulse,
	input  wire       frame_sync_loss,
	input  wire       superframe_sync_loss,
	input  wire       all_ones_alarm,
	input  wire       multiframe_sync_missing,
	input  wire       severely_bad_frame,
	input  wire       aux_pattern_seen,
	input  wire       remote_yellow_alarm,
	input  wire       remote_japan_frame_alarm,
	input  wire       ebit_zero_evt,
	input  wire       sa6_code_valid,
	input  wire [3:0] sa6_code,
	input  wire [5:0] exch_second_evts,
	input  wire [5:0] netterm_second_evts,
	input  wire       frame_lock_evt,
	input  wire       frame_lock_differs,
	input  wire       superframe_lock_evt,
	input  wire       multiframe_lock_evt,
	input  wire       crc_check_evt,
	input  wire       crc_error_evt,
	input  wire       iw_timer_expired,
	// Indirect status port, pins
	input  wire       status_cs_n,
	input  wire       status_rd_n,
	output reg  [7:0] status_data_ff,
	// Forced frame loss towards the framer
	output reg        force_frame_loss_ff
);
	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	reg [1:0] cs_sync_ff;
	reg [1:0] rd_sync_ff;
	reg       rd_prev_ff;
	wire      cs_act = ~cs_sync_ff[1];
	wire      rd_act = ~rd_sync_ff[1];
	wire      rd_pulse = cs_act & rd_act & ~rd_prev_ff;
	always @(posedge core_clk) begin
		if (rst) begin
			cs_sync_ff <= 2'h3;
			rd_sync_ff <= 2'h3;
			rd_prev_ff <= 1'b0;
		end else if (clk_en) begin
			cs_sync_ff <= {cs_sync_ff[0], status_cs_n};
			rd_sync_ff <= {rd_sync_ff[0], status_rd_n};
			rd_prev_ff <= cs_act & rd_act;
		end
	end
	// ----------------------------------------
	// Mode decode
	// ----------------------------------------
	wire is_e1   = (frame_mode == `FMAES_MODE_E1_BASIC) | (frame_mode == `FMAES_MODE_E1_CRC4);
	wire is_crc4 = (frame_mode == `FMAES_MODE_E1_CRC4);
	wire is_esf  = (frame_mode == `FMAES_MODE_ESF);
	wire is_sf   = (frame_mode == `FMAES_MODE_D4) | (frame_mode == `FMAES_MODE_CHAN96);
	// ----------------------------------------
	// Continuous E-bit seconds
	// ----------------------------------------
	reg [9:0] ebit_cnt_ff;
	reg [2:0] ebit_secs_ff;
	wire      ebit_sec_ok = (ebit_cnt_ff + {9'h0, ebit_zero_evt}) >= `FMAES_EBIT_MIN;
	wire      ebit_alarm = one_sec_pulse & ebit_sec_ok & (ebit_secs_ff == EBIT_SECS - 3'h1);
	always @(posedge core_clk) begin
		if (rst) begin
			ebit_cnt_ff  <= 10'h000;
			ebit_secs_ff <= 3'h0;
		end else if (clk_en) begin
			if (one_sec_pulse) begin
				ebit_cnt_ff <= 10'h000;
				if (!ebit_sec_ok || ebit_alarm)
					ebit_secs_ff <= 3'h0;
				else
					ebit_secs_ff <= ebit_secs_ff + 3'h1;
			end else if (ebit_zero_evt && ebit_cnt_ff != 10'h3FF) begin
				ebit_cnt_ff <= ebit_cnt_ff + 10'h001;
			end
		end
	end
	// ----------------------------------------
	// Excessive CRC detection
	// ----------------------------------------
	// Block windows, not sliding: cheap, may miss a burst split across windows.
	reg  [9:0] crc_chk_ff;
	reg  [9:0] crc_err_ff;
	reg  [8:0] crc_sec_ff;
	wire [9:0] err_nxt = crc_err_ff + {9'h0, crc_error_evt};
	wire       esf_sec_mode = is_esf & checksum_option[`FMAES_OPT_ESF_SEC];
	wire       win_end = crc_check_evt & (is_esf ? (crc_chk_ff == {4'h0, `FMAES_ESF_WIN_CHK} - 10'h1)
		: (crc_chk_ff == `FMAES_E1_WIN_CHK - 10'h1));
	wire       win_hit = win_end & (is_esf ? (err_nxt >= {4'h0, `FMAES_ESF_WIN_ERR})
		: (err_nxt > `FMAES_E1_WIN_ERR));
	wire       sec_hit = esf_sec_mode & one_sec_pulse & (crc_sec_ff > `FMAES_ESF_SEC_ERR);
	wire       crc_excess = ((is_esf & ~esf_sec_mode) | is_crc4) ? win_hit : sec_hit;
	always @(posedge core_clk) begin
		if (rst) begin
			crc_chk_ff <= 10'h000;
			crc_err_ff <= 10'h000;
			crc_sec_ff <= 9'h000;
			force_frame_loss_ff <= 1'b0;
		end else if (clk_en) begin
			if (win_end) begin
				crc_chk_ff <= 10'h000;
				crc_err_ff <= 10'h000;
			end else if (crc_check_evt) begin
				crc_chk_ff <= crc_chk_ff + 10'h001;
				crc_err_ff <= err_nxt;
			end
			if (one_sec_pulse)
				crc_sec_ff <= 9'h000;
			else if (crc_error_evt && crc_sec_ff != 9'h1FF)
				crc_sec_ff <= crc_sec_ff + 9'h001;
			force_frame_loss_ff <= crc_excess & ~checksum_option[`FMAES_OPT_NO_FORCE];
		end
	end
	// ----------------------------------------
	// Unavailable-state trackers, one per interface
	// ----------------------------------------
	// Bit order: exch local, exch far, netterm local, netterm far
	wire [3:0] outage_rpt;
	// Exchange local
	fmaes_outage_track #(
		.UNAVAIL_SECS(UNAVAIL_SECS)
	) exch_local_outage (
		.core_clk(core_clk),
		.rst(rst),
		.clk_en(clk_en),
		.one_sec_pulse(one_sec_pulse),
		.g826_mode(g826_mode),
		.severe_sec(exch_second_evts[2]),
		.outage_rpt_ff(outage_rpt[0])
	);
	// Exchange far end
	fmaes_outage_track #(
		.UNAVAIL_SECS(UNAVAIL_SECS)
	) exch_far_outage (
		.core_clk(core_clk),
		.rst(rst),
		.clk_en(clk_en),
		.one_sec_pulse(one_sec_pulse),
		.g826_mode(g826_mode),
		.severe_sec(exch_second_evts[5]),
		.outage_rpt_ff(outage_rpt[1])
	);
	// Netterm local
	fmaes_outage_track #(
		.UNAVAIL_SECS(UNAVAIL_SECS)
	) nt_local_outage (
		.core_clk(core_clk),
		.rst(rst),
		.clk_en(clk_en),
		.one_sec_pulse(one_sec_pulse),
		.g826_mode(g826_mode),
		.severe_sec(netterm_second_evts[2]),
		.outage_rpt_ff(outage_rpt[2])
	);
	// Netterm far end
	fmaes_outage_track #(
		.UNAVAIL_SECS(UNAVAIL_SECS)
	) nt_far_outage (
		.core_clk(core_clk),
		.rst(rst),
		.clk_en(clk_en),
		.one_sec_pulse(one_sec_pulse),
		.g826_mode(g826_mode),
		.severe_sec(netterm_second_evts[5]),
		.outage_rpt_ff(outage_rpt[3])
	);
	// ----------------------------------------
	// Raw conditions per register
	// ----------------------------------------
	wire [7:0] fac_cond;
	wire [7:0] rem_cond;
	wire [7:0] exch_cond;
	wire [7:0] nt_cond;
	wire [7:0] aln_cond;
	wire [4:0] sa6_hit = {sa6_code == 4'hF, sa6_code == 4'hE, sa6_code == 4'hC,
		sa6_code == 4'hA, sa6_code == 4'h8};
	// Facility alarms
	assign fac_cond[0] = frame_sync_loss;
	assign fac_cond[1] = superframe_sync_loss & is_sf;
	assign fac_cond[2] = all_ones_alarm;
	// Bit 3 is formed at read time from bit 0
	assign fac_cond[3] = 1'b0;
	assign fac_cond[4] = multiframe_sync_missing & is_crc4;
	assign fac_cond[5] = severely_bad_frame;
	assign fac_cond[6] = 1'b0;
	assign fac_cond[7] = aux_pattern_seen & frame_sync_loss & is_e1;
	// Remote alarms
	assign rem_cond[0] = remote_yellow_alarm;
	assign rem_cond[1] = remote_japan_frame_alarm & ~is_e1;
	assign rem_cond[2] = ebit_alarm & is_e1;
	assign rem_cond[7:3] = sa6_hit & {5{sa6_code_valid & is_e1}};
	// Exchange seconds; far end exists only in E1
	assign exch_cond[2:0] = exch_second_evts[2:0];
	assign exch_cond[3] = outage_rpt[0];
	assign exch_cond[6:4] = exch_second_evts[5:3] & {3{is_e1}};
	assign exch_cond[7] = outage_rpt[1] & is_e1;
	// Netterm seconds, all zero in DS1
	assign nt_cond[2:0] = netterm_second_evts[2:0] & {3{is_e1}};
	assign nt_cond[3] = outage_rpt[2] & is_e1;
	assign nt_cond[6:4] = netterm_second_evts[5:3] & {3{is_e1}};
	assign nt_cond[7] = outage_rpt[3] & is_e1;
	// Alignment and CRC events
	assign aln_cond[0] = frame_lock_evt & frame_lock_differs;
	assign aln_cond[1] = superframe_lock_evt & is_sf & ~frame_sync_loss;
	assign aln_cond[2] = multiframe_lock_evt & (is_esf | is_crc4);
	assign aln_cond[5:3] = 3'h0;
	assign aln_cond[6] = crc_excess & (is_esf | is_crc4);
	assign aln_cond[7] = iw_timer_expired & is_crc4 & (iw_timer_mode != `FMAES_TMR_NONE);
	// ----------------------------------------
	// Latched detail flags
	// ----------------------------------------
	reg  [7:0] fac_ff;
	reg  [7:0] rem_ff;
	reg  [7:0] exch_ff;
	reg  [7:0] nt_ff;
	reg  [7:0] aln_ff;
	reg  [2:0] rd_idx_ff;
	reg        lfa_at_read_ff;
	wire [7:0] fac_rd = {fac_ff[7:4], (fac_ff[0] == lfa_at_read_ff), fac_ff[2:0]}
		& `FMAES_FAC_RSVD_MASK;
	wire [7:0] summary = {3'h0, |aln_ff, |nt_ff, |exch_ff, |rem_ff, |fac_ff};
	reg  [7:0] nxt_data;
	always @* begin
		case (rd_idx_ff)
			`FMAES_IDX_SUMMARY:   nxt_data = summary;
			`FMAES_IDX_FAC_ALARM: nxt_data = fac_rd;
			`FMAES_IDX_REM_ALARM: nxt_data = rem_ff;
			`FMAES_IDX_EXCH_EVT:  nxt_data = exch_ff;
			`FMAES_IDX_NT_EVT:    nxt_data = nt_ff;
			`FMAES_IDX_ALIGN_EVT: nxt_data = aln_ff & `FMAES_ALN_RSVD_MASK;
			default:              nxt_data = 8'h00;
		endcase
	end
	// Set beats clear: a condition present in the read cycle survives the read
	wire rd_fac  = rd_pulse & (rd_idx_ff == `FMAES_IDX_FAC_ALARM);
	wire rd_rem  = rd_pulse & (rd_idx_ff == `FMAES_IDX_REM_ALARM);
	wire rd_exch = rd_pulse & (rd_idx_ff == `FMAES_IDX_EXCH_EVT);
	wire rd_nt   = rd_pulse & (rd_idx_ff == `FMAES_IDX_NT_EVT);
	wire rd_aln  = rd_pulse & (rd_idx_ff == `FMAES_IDX_ALIGN_EVT);
	always @(posedge core_clk) begin
		if (rst) begin
			fac_ff         <= `FMAES_FLAG_RESET;
			rem_ff         <= `FMAES_FLAG_RESET;
			exch_ff        <= `FMAES_FLAG_RESET;
			nt_ff          <= `FMAES_FLAG_RESET;
			aln_ff         <= `FMAES_FLAG_RESET;
			rd_idx_ff      <= `FMAES_IDX_SUMMARY;
			lfa_at_read_ff <= 1'b0;
			status_data_ff <= 8'h00;
		end else if (clk_en) begin
			fac_ff  <= (rd_fac ? 8'h00 : fac_ff) | fac_cond;
			rem_ff  <= (rd_rem ? 8'h00 : rem_ff) | rem_cond;
			exch_ff <= (rd_exch ? 8'h00 : exch_ff) | exch_cond;
			nt_ff   <= (rd_nt ? 8'h00 : nt_ff) | nt_cond;
			aln_ff  <= (rd_aln ? 8'h00 : aln_ff) | aln_cond;
			if (rd_fac)
				lfa_at_read_ff <= fac_ff[0];
			if (!cs_act) begin
				rd_idx_ff <= `FMAES_IDX_SUMMARY;
			end else if (rd_pulse) begin
				status_data_ff <= nxt_data;
				if (rd_idx_ff != `FMAES_IDX_LAST)
					rd_idx_ff <= rd_idx_ff + 3'h1;
				else
					rd_idx_ff <= `FMAES_IDX_LAST;
			end
		end
	end
endmodule

// ----------------------------------------
// Unavailable-state tracker, one per interface
// ----------------------------------------
module fmaes_outage_track #(
	parameter [3:0] UNAVAIL_SECS = `FMAES_UNAVAIL_SECS
) (
	// Clock, reset, enable
	input  wire core_clk,
	input  wire rst,
	input  wire clk_en,
	// Second timing and mode
	input  wire one_sec_pulse,
	input  wire g826_mode,
	// Severely errored second of this interface
	input  wire severe_sec,
	// Reported unavailable state
	output reg  outage_rpt_ff
);
	reg  [3:0] sev_run_ff;
	reg  [3:0] hold_ff;
	reg        outage_ff;
	wire       run_full   = severe_sec & (sev_run_ff == UNAVAIL_SECS - 4'h1);
	wire       nxt_outage = severe_sec & (outage_ff | run_full);
	wire       hold_done  = hold_ff >= UNAVAIL_SECS - 4'h1;
	// ----------------------------------------
	// Severe-second run
	// ----------------------------------------
	// Exit simplified: one clean second leaves the state
	always @(posedge core_clk) begin
		if (rst) begin
			sev_run_ff    <= 4'h0;
			outage_ff     <= 1'b0;
			outage_rpt_ff <= 1'b0;
		end else if (clk_en && one_sec_pulse) begin
			if (!severe_sec)
				sev_run_ff <= 4'h0;
			else if (sev_run_ff != UNAVAIL_SECS)
				sev_run_ff <= sev_run_ff + 4'h1;
			outage_ff     <= nxt_outage;
			outage_rpt_ff <= nxt_outage & (~g826_mode | hold_done);
		end
	end
	// ----------------------------------------
	// G.826 report hold
	// ----------------------------------------
	// Report held back ten further seconds
	always @(posedge core_clk) begin
		if (rst) begin
			hold_ff <= 4'h0;
		end else if (clk_en && one_sec_pulse) begin
			if (!outage_ff)
				hold_ff <= 4'h0;
			else if (!hold_done)
				hold_ff <= hold_ff + 4'h1;
		end
	end
endmodule

// *** dv/fmaes_host_model.sv ***
module fmaes_host_model (
	// Clock
	input  logic       core_clk,
	// Indirect status port
	output logic       status_cs_n,
	output logic       status_rd_n,
	input  logic [7:0] status_data_ff
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] got [0:7];
	initial begin
		status_cs_n = 1'b1;
		status_rd_n = 1'b1;
	end
	// Select held over the whole burst; strobes spaced past the pin synchronisers
	task automatic burst(input int n);
		@(posedge core_clk) #1 status_cs_n = 1'b0;
		for (int i = 0; i < n; i++) begin
			@(posedge core_clk) #1 status_rd_n = 1'b0;
			repeat (4) @(posedge core_clk);
			got[i] = status_data_ff;
			#1 status_rd_n = 1'b1;
			repeat (3) @(posedge core_clk);
		end
		#1 status_cs_n = 1'b1;
		repeat (4) @(posedge core_clk);
		#1;
	endtask
endmodule

// *** dv/fmaes_status_asserts.sv ***
`include "fmaes_defines.vh"
module fmaes_status_asserts (
	// Clock and reset
	input logic       core_clk,
	input logic       rst,
	// Configuration and pins
	input logic [2:0] frame_mode,
	input logic [1:0] iw_timer_mode,
	input logic [1:0] checksum_option,
	input logic       status_cs_n,
	input logic       status_rd_n,
	input logic [7:0] status_data_ff,
	input logic       force_frame_loss_ff
);
	timeunit 1ns;
	timeprecision 100ps;
	// ------
	// Shadow read index, same sync depth as the pins
	// ------
	logic [1:0] cs_s_ff;
	logic [2:0] rd_s_ff;
	logic [2:0] idx_ff;
	logic [2:0] nxt_idx;
	wire        hit  = !cs_s_ff[1] && !rd_s_ff[1] && rd_s_ff[2];
	wire        ds1  = frame_mode < `FMAES_MODE_E1_BASIC;
	wire        crc4 = frame_mode == `FMAES_MODE_E1_CRC4;
	wire        sfm  = frame_mode == `FMAES_MODE_D4 || frame_mode == `FMAES_MODE_CHAN96;
	wire [7:0]  d    = status_data_ff;
	always @* begin
		nxt_idx = idx_ff;
		if (cs_s_ff[1])
			nxt_idx = 3'h0;
		else if (hit && idx_ff != `FMAES_IDX_LAST)
			nxt_idx = idx_ff + 3'h1;
	end
	always @(posedge core_clk) begin
		cs_s_ff <= {cs_s_ff[0], status_cs_n};
		rd_s_ff <= {rd_s_ff[1:0], status_rd_n};
		idx_ff  <= rst ? 3'h0 : nxt_idx;
	end
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	a_reset_clears_outputs: assert property (disable iff (1'b0) rst |=> d == 8'h00 && !force_frame_loss_ff)
		else $error("outputs not cleared by reset");
	a_data_on_read: assert property (!$stable(d) |-> !$past(status_rd_n, 3) && !$past(status_cs_n, 3))
		else $error("read data changed without a read");
	a_force_single: assert property (force_frame_loss_ff |=> !force_frame_loss_ff [*3])
		else $error("forced frame loss longer than one cycle");
	a_force_cause: assert property (force_frame_loss_ff |-> !$past(checksum_option[0]) && ($past(frame_mode) == 3'h0 || $past(frame_mode) == 3'h5))
		else $error("forced frame loss without enable");
	a_fac_fixed_bits: assert property (hit && idx_ff == 3'h1 |=> !d[6] && (crc4 || !d[4]) && (!ds1 || !d[7]))
		else $error("facility alarm fixed bit set");
	a_fac_superframe: assert property (hit && idx_ff == 3'h1 && !sfm |=> !d[1])
		else $error("superframe loss outside its formats");
	a_remote_modes: assert property (hit && idx_ff == 3'h2 |=> (!ds1 || d[7:2] == 6'h00) && (ds1 || !d[1]))
		else $error("remote alarm bit in wrong mode");
	a_exch_far_ds1: assert property (hit && ds1 && idx_ff == 3'h3 |=> d[7:4] == 4'h0)
		else $error("far end exchange flag in DS1");
	a_netterm_ds1: assert property (hit && ds1 && idx_ff == 3'h4 |=> d == 8'h00)
		else $error("netterm flags in DS1");
	a_align_fixed: assert property (hit && idx_ff == 3'h5 |=> d[5:3] == 3'h0 && (sfm || !d[1]) && (crc4 && iw_timer_mode != `FMAES_TMR_NONE || !d[7]))
		else $error("alignment event fixed bit set");
	a_summary_rsvd: assert property (hit && idx_ff == 3'h0 |=> d[7:5] == 3'h0)
		else $error("summary spare bit set");
	cover property (hit && idx_ff == 3'h5);
	cover property (force_frame_loss_ff);
	cover property (hit && idx_ff == 3'h0 ##1 d != 8'h00);
endmodule
bind fmaes_status fmaes_status_asserts fmaes_status_asserts_inst (.core_clk(core_clk), .rst(rst), .frame_mode(frame_mode),
	.iw_timer_mode(iw_timer_mode), .checksum_option(checksum_option), .status_cs_n(status_cs_n),
	.status_rd_n(status_rd_n), .status_data_ff(status_data_ff), .force_frame_loss_ff(force_frame_loss_ff));

// *** dv/testbench.sv ***
module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	typedef struct packed {
		logic [2:0]  mode;
		logic [13:0] cond;
		logic [3:0]  code;
		logic [5:0]  ex;
		logic [5:0]  nt;
		logic [39:0] exp;
	} fmaes_row_t;
	logic        core_clk = 1'b0;
	logic        rst = 1'b1;
	logic [2:0]  frame_mode = 3'h0;
	logic [1:0]  checksum_option = 2'h0;
	logic [13:0] cond = 14'h0000;
	logic [3:0]  sa6_code = 4'h0;
	logic [5:0]  exch_ev = 6'h00;
	logic [5:0]  nt_ev = 6'h00;
	logic        g826 = 1'b0;
	logic [1:0]  iw_mode = 2'h1;
	logic        sec = 1'b0;
	logic        ebit = 1'b0;
	logic        chk = 1'b0;
	logic        err = 1'b0;
	logic        last_b0 = 1'b0;
	wire         cs_n;
	wire         rd_n;
	wire         force_fl;
	wire [7:0]   data;
	int          num_errors = 0;
	int          total_checks = 0;
	int          fcnt = 0;
	int          crc_tab [0:5][0:5] = '{'{0,0,33,32,1,1}, '{0,0,33,31,0,0}, '{0,3,321,321,1,0},
		'{0,2,320,320,0,0}, '{5,0,1000,915,1,1}, '{5,0,1000,914,0,0}};
	fmaes_row_t  rows [0:17] = '{
		'{3'h0,14'h0000,4'h0,6'h00,6'h00,40'h0000000000}, '{3'h0,14'h003F,4'h0,6'h00,6'h00,40'h2500000000},
		'{3'h1,14'h0042,4'h0,6'h00,6'h00,40'h0201000000}, '{3'h3,14'h0A02,4'h0,6'h00,6'h00,40'h0200000002},
		'{3'h5,14'h36E1,4'h0,6'h00,6'h00,40'h8101000085}, '{3'h4,14'h280A,4'h0,6'h00,6'h00,40'h0000000000},
		'{3'h0,14'h3700,4'h8,6'h00,6'h00,40'h0000000005}, '{3'h5,14'h0100,4'h8,6'h00,6'h00,40'h0008000000},
		'{3'h5,14'h0100,4'hA,6'h00,6'h00,40'h0010000000}, '{3'h5,14'h0100,4'hC,6'h00,6'h00,40'h0020000000},
		'{3'h5,14'h0100,4'hE,6'h00,6'h00,40'h0040000000}, '{3'h5,14'h0100,4'hF,6'h00,6'h00,40'h0080000000},
		'{3'h5,14'h0100,4'h9,6'h00,6'h00,40'h0000000000}, '{3'h0,14'h0000,4'h0,6'h07,6'h07,40'h0000070000},
		'{3'h5,14'h0000,4'h0,6'h01,6'h07,40'h0000010700}, '{3'h2,14'h0080,4'h0,6'h00,6'h00,40'h0002000000},
		'{3'h5,14'h0008,4'h0,6'h00,6'h00,40'h1000000000}, '{3'h5,14'h0000,4'h0,6'h38,6'h38,40'h0000707000}};
	fmaes_status fmaes_status_inst (.core_clk(core_clk), .rst(rst), .clk_en(1'b1), .frame_mode(frame_mode),
		.iw_timer_mode(iw_mode), .g826_mode(g826), .checksum_option(checksum_option), .one_sec_pulse(sec),
		.frame_sync_loss(cond[0]), .superframe_sync_loss(cond[1]), .all_ones_alarm(cond[2]),
		.multiframe_sync_missing(cond[3]), .severely_bad_frame(cond[4]), .aux_pattern_seen(cond[5]),
		.remote_yellow_alarm(cond[6]), .remote_japan_frame_alarm(cond[7]), .ebit_zero_evt(ebit),
		.sa6_code_valid(cond[8]), .sa6_code(sa6_code), .exch_second_evts(exch_ev), .netterm_second_evts(nt_ev),
		.frame_lock_evt(cond[9]), .frame_lock_differs(cond[10]), .superframe_lock_evt(cond[11]),
		.multiframe_lock_evt(cond[12]), .crc_check_evt(chk), .crc_error_evt(err), .iw_timer_expired(cond[13]),
		.status_cs_n(cs_n), .status_rd_n(rd_n), .status_data_ff(data), .force_frame_loss_ff(force_fl));
	fmaes_host_model fmaes_host_model_inst (.core_clk(core_clk), .status_cs_n(cs_n), .status_rd_n(rd_n),
		.status_data_ff(data));
	always #2.5 core_clk = ~core_clk;
	always @(posedge core_clk)
		if (force_fl === 1'b1)
			fcnt++;
	task automatic check8(input logic [7:0] got, input logic [7:0] want);
		total_checks++;
		if (got !== want) begin
			num_errors++;
			$display("mismatch at %0t: got %h want %h", $time, got, want);
		end
	endtask
	task automatic close_out;
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic tick;
		@(posedge core_clk) #1;
	endtask
	task automatic do_reset(input int m, input int opt);
		tick;
		rst = 1'b1;
		frame_mode = 3'(m);
		checksum_option = 2'(opt);
		repeat (6) tick;
		rst = 1'b0;
		fcnt = 0;
		last_b0 = 1'b0;
	endtask
	// Summary and same-as-last-read bit follow from the detail bytes
	task automatic check_burst(input logic [39:0] exp);
		logic [7:0] want [0:6];
		want[0] = 8'h00;
		for (int j = 1; j < 6; j++) begin
			want[j] = exp[8 * (5 - j) +: 8];
			want[0][j - 1] = |want[j];
		end
		want[1][3] = (want[1][0] === last_b0);
		last_b0 = want[1][0];
		want[6] = 8'h00;
		fmaes_host_model_inst.burst(7);
		for (int j = 0; j < 7; j++)
			check8(fmaes_host_model_inst.got[j], want[j]);
	endtask
	task automatic seconds(input int n, input int nb, input logic [5:0] ex);
		repeat (n) begin
			repeat (nb) begin
				ebit = 1'b1;
				tick;
				ebit = 1'b0;
				tick;
			end
			sec = 1'b1;
			exch_ev = ex;
			tick;
			sec = 1'b0;
			exch_ev = 6'h00;
			tick;
		end
	endtask
	initial begin
		repeat (90000) @(posedge core_clk);
		num_errors++;
		close_out;
	end
	initial begin
		do_reset(0, 0);
		foreach (rows[i]) begin
			tick;
			frame_mode = rows[i].mode;
			tick;
			{cond, sa6_code, exch_ev, nt_ev} = {rows[i].cond, rows[i].code, rows[i].ex, rows[i].nt};
			sec = |{rows[i].ex, rows[i].nt};
			tick;
			{cond, exch_ev, nt_ev, sec} = 27'h0000000;
			check_burst(rows[i].exp);
			check_burst(40'h0000000000);
		end
		// Condition still present at the read keeps its flag
		cond = 14'h0001;
		repeat (2) check_burst(40'h0100000000);
		cond = 14'h0000;
		check_burst(40'h0100000000);
		check_burst(40'h0000000000);
		cond = 14'h0004;
		tick;
		cond = 14'h0000;
		fmaes_host_model_inst.burst(1);
		check8(fmaes_host_model_inst.got[0], 8'h01);
		check_burst(40'h0400000000);
		foreach (crc_tab[i]) begin
			do_reset(crc_tab[i][0], crc_tab[i][1]);
			for (int k = 0; k < crc_tab[i][2]; k++) begin
				{chk, err} = {1'b1, k < crc_tab[i][3]};
				tick;
			end
			{chk, err, sec} = 3'h1;
			tick;
			sec = 1'b0;
			repeat (4) tick;
			check8(8'(fcnt), 8'(crc_tab[i][5]));
			check_burst({32'h00000000, 1'b0, crc_tab[i][4] == 1, 6'h00});
		end
		do_reset(5, 1);
		seconds(5, 991, 6'h00);
		check_burst(40'h0004000000);
		do_reset(5, 1);
		seconds(4, 991, 6'h00);
		seconds(1, 990, 6'h00);
		check_burst(40'h0000000000);
		do_reset(0, 1);
		seconds(9, 0, 6'h04);
		check_burst(40'h0000040000);
		seconds(1, 0, 6'h04);
		check_burst(40'h00000C0000);
		// G.826 holds the outage report ten further seconds
		do_reset(0, 1);
		g826 = 1'b1;
		seconds(19, 0, 6'h04);
		check_burst(40'h0000040000);
		seconds(1, 0, 6'h04);
		check_burst(40'h00000C0000);
		g826 = 1'b0;
		// No interworking timer selected: expiry never flagged
		iw_mode = 2'h0;
		do_reset(5, 1);
		cond = 14'h2000;
		tick;
		cond = 14'h0000;
		check_burst(40'h0000000000);
		close_out;
	end
endmodule
